//--- verilog/bridge_window_decode_status.sv
// Address-window decoder, bus numbers and secondary status for one bridge.
`timescale 1ns/1ps
`default_nettype none
module bridge_window_decode_status
  import bridge_window_pkg::*;
(
  // Clock and resets.
  input wire logic clock,
  input wire logic reset,
  input wire logic power_good_reset,
  // Mode strap and configuration.
  input wire logic pcix_mode,
  input wire logic last_in_chain,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host-side request.
  input wire logic host_valid,
  input wire logic host_is_io,
  input wire logic [39:0] host_addr,
  output logic host_to_secondary,
  output logic host_pass_on,
  output logic host_master_abort,
  // Secondary-side request.
  input wire logic sec_valid,
  input wire logic sec_is_io,
  input wire logic [63:0] sec_addr,
  output logic sec_claim,
  output logic [1:0] sec_devsel_timing,
  // Secondary events from the bus engine.
  input wire logic ev_addr_parity,
  input wire logic ev_upstream_data_parity,
  input wire logic ev_master_abort,
  input wire logic ev_target_abort,
  input wire logic ev_target_abort_signalled,
  input wire logic ev_read_data_parity,
  input wire logic ev_write_parity_error,
  // Error pins, asynchronous; the system-error pin is low active, the hot-plug pin high active.
  input wire logic secondary_system_error_in_n,
  input wire logic hotplug_system_error_in,
  // Hot-plug base for the hot-plug register decoder.
  output logic hotplug_enable,
  output logic [39:0] hotplug_base_address
);

  // The block keeps the window registers and the secondary status word for one
  // bridge. It also classifies every host and secondary request against the
  // IO, non-prefetchable and prefetchable windows. Each classification is
  // registered, so an answer always follows its request by exactly one clock.
  // Register writes and status clears take effect on the edge at which the
  // bus sees ack high. A master that drops its request early therefore
  // leaves nothing half written.

  logic [63:12] hp_base_q;
  logic [4:0] lat_q;
  logic [7:0] sub_bus_q, sec_bus_q, pri_bus_q;
  logic [3:0] io_lim_lo_q, io_base_lo_q;
  logic [11:0] np_lim_q, np_base_q, pf_lim_q, pf_base_q;
  logic [7:0] pf_base_hi_q, pf_lim_hi_q, np_base_ext_q, np_lim_ext_q;
  logic [8:0] io_base_hi_q, io_lim_hi_q;
  logic parity_response_enable_q, hotplug_enable_a_q, hotplug_enable_b_q;
  logic f_dpe_q, f_rse_q, f_rma_q, f_rta_q, f_sta_q, f_master_parity_flag_q;
  logic [2:0] serr_sync_q, hpse_sync_q;
  logic serr_level, hpse_level;
  logic ack_q;
  logic [31:0] rdata_d;
  logic wr, rd;

  // A write lands on the edge that samples ack high; the request still stands there.
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign rd = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_ack_o = ack_q;

  // One wait state: ack rises the cycle after the request and drops after one cycle.
  always_ff @(posedge clock) begin
    if (reset | power_good_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic w1c(input logic [31:0] d, input logic [3:0] sel, input int bitn);
    return d[bitn] & sel[bitn / 8];
  endfunction : w1c

  // Byte-lane merges are formed once as whole words. A function result cannot
  // be sliced directly, and one merge per word keeps the lanes consistent.
  logic [31:0] hp_lo_new, np_new, pf_new, io_up_new;
  assign hp_lo_new = merge({hp_base_q[31:12], 12'h000}, wb_dat_i, wb_sel_i);
  assign np_new = merge({np_lim_q, 4'h0, np_base_q, 4'h0}, wb_dat_i, wb_sel_i);
  assign pf_new = merge({pf_lim_q, 4'h0, pf_base_q, 4'h0}, wb_dat_i, wb_sel_i);
  assign io_up_new = merge({7'h00, io_lim_hi_q, 7'h00, io_base_hi_q}, wb_dat_i,
                           wb_sel_i);

  // Pins from the secondary bus pass three flops; a change counts when stages two and three agree.
  always_ff @(posedge clock) begin
    if (power_good_reset) begin
      serr_sync_q <= 3'b000;
      hpse_sync_q <= 3'b000;
      serr_level <= 1'b0;
      hpse_level <= 1'b0;
    end else begin
      serr_sync_q <= {serr_sync_q[1:0], ~secondary_system_error_in_n};
      hpse_sync_q <= {hpse_sync_q[1:0], hotplug_system_error_in};
      if (serr_sync_q[2] == serr_sync_q[1]) serr_level <= serr_sync_q[2];
      if (hpse_sync_q[2] == hpse_sync_q[1]) hpse_level <= hpse_sync_q[2];
    end
  end

  // Hot-plug base: writes land only while hot-plug is enabled.
  always_ff @(posedge clock) begin
    if (power_good_reset) begin
      hp_base_q <= '0;
    end else if (wr && hotplug_enable) begin
      if (wb_adr_i == hotplug_base_lo_offset) begin
        hp_base_q[31:12] <= hp_lo_new[31:12];
      end else if (wb_adr_i == hotplug_base_hi_offset) begin
        hp_base_q[63:32] <= merge(hp_base_q[63:32], wb_dat_i, wb_sel_i);
      end
    end
  end
  assign hotplug_enable = hotplug_enable_a_q | hotplug_enable_b_q;
  // Bits 63:40 are assumed zero by software and are not decoded.
  assign hotplug_base_address = {hp_base_q[39:12], 12'h000};

  // Bus numbers and latency: latency reloads on bus reset by mode.
  always_ff @(posedge clock) begin
    if (reset | power_good_reset) begin
      lat_q <= pcix_mode ? latency_pcix_reset[7:3] : latency_pci_reset[7:3];
      sub_bus_q <= 8'h00;
      sec_bus_q <= 8'h00;
      pri_bus_q <= 8'h00;
    end else if (wr && wb_adr_i == bus_numbers_offset) begin
      if (wb_sel_i[3]) lat_q <= wb_dat_i[31:27];
      if (wb_sel_i[2]) sub_bus_q <= wb_dat_i[23:16];
      if (wb_sel_i[1]) sec_bus_q <= wb_dat_i[15:8];
      if (wb_sel_i[0]) pri_bus_q <= wb_dat_i[7:0];
    end
  end

  // Window and control registers. Word layouts as seen by software:
  //   0x1c: io limit nibble in 15:12, io base nibble in 7:4.
  //   0x20: non-prefetchable limit in 31:20, base in 15:4.
  //   0x24: prefetchable limit in 31:20, base in 15:4.
  //   0x28, 0x2c: prefetchable base and limit bits 39:32 in 7:0.
  //   0x30: io limit upper bits in 24:16, io base upper bits in 8:0.
  //   0xd8: non-prefetchable limit extension in 15:8, base extension in 7:0.
  //   0x3c: parity response enable in bit 16.
  //   0x48: hot-plug enables in bits 1:0.
  // Bus reset puts every window back to its inverted default, so nothing is
  // routed downstream until software has programmed the windows again.
  always_ff @(posedge clock) begin
    if (reset | power_good_reset) begin
      io_lim_lo_q <= status_io_reset[15:12];
      io_base_lo_q <= status_io_reset[7:4];
      np_lim_q <= nonprefetch_reset[31:20];
      np_base_q <= nonprefetch_reset[15:4];
      pf_lim_q <= prefetch_low_reset[31:20];
      pf_base_q <= prefetch_low_reset[15:4];
      pf_base_hi_q <= 8'h00;
      pf_lim_hi_q <= 8'h00;
      io_lim_hi_q <= io_upper_reset[24:16];
      io_base_hi_q <= io_upper_reset[8:0];
      np_base_ext_q <= 8'h00;
      np_lim_ext_q <= 8'h00;
      parity_response_enable_q <= 1'b0;
      hotplug_enable_a_q <= 1'b0;
      hotplug_enable_b_q <= 1'b0;
    end else if (wr) begin
      unique case (wb_adr_i)
        status_io_low_offset: begin
          if (wb_sel_i[1]) io_lim_lo_q <= wb_dat_i[15:12];
          if (wb_sel_i[0]) io_base_lo_q <= wb_dat_i[7:4];
        end
        nonprefetch_offset: begin
          np_lim_q <= np_new[31:20];
          np_base_q <= np_new[15:4];
        end
        prefetch_low_offset: begin
          pf_lim_q <= pf_new[31:20];
          pf_base_q <= pf_new[15:4];
        end
        prefetch_base_hi_offset: if (wb_sel_i[0]) pf_base_hi_q <= wb_dat_i[7:0];
        prefetch_limit_hi_offset: if (wb_sel_i[0]) pf_lim_hi_q <= wb_dat_i[7:0];
        io_upper_offset: begin
          io_lim_hi_q <= io_up_new[24:16];
          io_base_hi_q <= io_up_new[8:0];
        end
        upper_ext_offset: begin
          if (wb_sel_i[1]) np_lim_ext_q <= wb_dat_i[15:8];
          if (wb_sel_i[0]) np_base_ext_q <= wb_dat_i[7:0];
        end
        control_offset: if (wb_sel_i[2]) parity_response_enable_q <= wb_dat_i[16];
        hotplug_enable_offset: begin
          if (wb_sel_i[0]) hotplug_enable_a_q <= wb_dat_i[0];
          if (wb_sel_i[0]) hotplug_enable_b_q <= wb_dat_i[1];
        end
        default: ;
      endcase
    end
  end

  // Status flags: power-good only; a set in the same cycle beats a clear.
  logic st_wr;
  assign st_wr = wr && wb_adr_i == status_io_low_offset;
  always_ff @(posedge clock) begin
    if (power_good_reset) begin
      f_dpe_q <= 1'b0;
      f_rse_q <= 1'b0;
      f_rma_q <= 1'b0;
      f_rta_q <= 1'b0;
      f_sta_q <= 1'b0;
      f_master_parity_flag_q <= 1'b0;
    end else begin
      if (ev_addr_parity | ev_upstream_data_parity) begin
        f_dpe_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_parity)) begin
        f_dpe_q <= 1'b0;
      end
      // The level re-sets the flag every cycle, so a clear only sticks once
      // both error inputs have gone quiet.
      if (serr_level | hpse_level) begin
        f_rse_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_system_error)) begin
        f_rse_q <= 1'b0;
      end
      if (ev_master_abort) begin
        f_rma_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_master_abort)) begin
        f_rma_q <= 1'b0;
      end
      if (ev_target_abort) begin
        f_rta_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_target_abort)) begin
        f_rta_q <= 1'b0;
      end
      if (ev_target_abort_signalled) begin
        f_sta_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_target_signalled)) begin
        f_sta_q <= 1'b0;
      end
      if (parity_response_enable_q & (ev_read_data_parity | ev_write_parity_error)) begin
        f_master_parity_flag_q <= 1'b1;
      end else if (st_wr && w1c(wb_dat_i, wb_sel_i, flag_master_parity)) begin
        f_master_parity_flag_q <= 1'b0;
      end
    end
  end

  // Read mux; unmapped offsets read zero and still acknowledge.
  always_comb begin
    rdata_d = 32'h0;
    unique case (wb_adr_i)
      hotplug_base_lo_offset: if (hotplug_enable) rdata_d = {hp_base_q[31:12], 8'h00,
                                                          hotplug_base_low_bits};
      hotplug_base_hi_offset: if (hotplug_enable) rdata_d = hp_base_q[63:32];
      bus_numbers_offset: rdata_d = {lat_q, 3'b000, sub_bus_q, sec_bus_q, pri_bus_q};
      status_io_low_offset: rdata_d = {f_dpe_q, f_rse_q, f_rma_q, f_rta_q, f_sta_q,
                                       devsel_medium, f_master_parity_flag_q, 1'b0, status_fixed_bits,
                                       io_lim_lo_q, status_io_reset[11:8], io_base_lo_q,
                                       4'h1};
      nonprefetch_offset: rdata_d = {np_lim_q, 4'h0, np_base_q, 4'h0};
      prefetch_low_offset: rdata_d = {pf_lim_q, 4'h1, pf_base_q, 4'h1};
      prefetch_base_hi_offset: rdata_d = {24'h0, pf_base_hi_q};
      prefetch_limit_hi_offset: rdata_d = {24'h0, pf_lim_hi_q};
      io_upper_offset: rdata_d = {7'h00, io_lim_hi_q, 7'h00, io_base_hi_q};
      upper_ext_offset: rdata_d = {16'h0, np_lim_ext_q, np_base_ext_q};
      control_offset: rdata_d = {15'h0, parity_response_enable_q, 16'h0};
      hotplug_enable_offset: rdata_d = {30'h0, hotplug_enable_b_q, hotplug_enable_a_q};
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset | power_good_reset) wb_dat_o <= 32'h0;
    else if (rd) wb_dat_o <= rdata_d;
  end

  // Window decode; an inverted window simply never matches.
  logic [31:0] io_lo, io_hi, h_io, s_io;
  logic [39:0] np_lo, np_hi, pf_lo, pf_hi, h_mem, s_mem;
  logic h_hit, s_hit, s_ok;
  assign io_hi = {7'h00, io_lim_hi_q, io_lim_lo_q, 12'hfff};
  assign io_lo = {7'h00, io_base_hi_q, io_base_lo_q, 12'h000};
  assign np_hi = {np_lim_ext_q, np_lim_q, 20'hf_ffff};
  assign np_lo = {np_base_ext_q, np_base_q, 20'h0_0000};
  assign pf_hi = {pf_lim_hi_q, pf_lim_q, 20'hf_ffff};
  assign pf_lo = {pf_base_hi_q, pf_base_q, 20'h0_0000};
  assign h_io = {7'h00, host_addr[24:0]};
  assign s_io = sec_addr[31:0];
  assign h_mem = host_addr;
  assign s_mem = sec_addr[39:0];

  function automatic logic in_win(input logic [39:0] a, input logic [39:0] lo,
                                  input logic [39:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_win

  // Each window is compared on its own. An inverted window in one space
  // therefore cannot hide a hit in another space.
  logic h_io_hit, h_np_hit, h_pf_hit, s_io_hit, s_np_hit, s_pf_hit;
  assign h_io_hit = in_win({8'h00, h_io}, {8'h00, io_lo}, {8'h00, io_hi});
  assign h_np_hit = in_win(h_mem, np_lo, np_hi);
  assign h_pf_hit = in_win(h_mem, pf_lo, pf_hi);
  assign s_io_hit = in_win({8'h00, s_io}, {8'h00, io_lo}, {8'h00, io_hi});
  assign s_np_hit = in_win(s_mem, np_lo, np_hi);
  assign s_pf_hit = in_win(s_mem, pf_lo, pf_hi);
  assign h_hit = host_is_io ? h_io_hit : (h_np_hit | h_pf_hit);
  assign s_hit = sec_is_io ? s_io_hit : (s_np_hit | s_pf_hit);
  // Secondary addresses beyond the reach of the host link are left for some
  // other agent on the bus; claiming them would alias into the link space.
  assign s_ok = sec_is_io ? (sec_addr[31:25] == 7'h00) && (sec_addr[63:32] == 32'h0)
                          : (sec_addr[63:40] == 24'h0);

  // Host-side routing: exactly one of the three outputs answers a request.
  always_ff @(posedge clock) begin
    if (reset | power_good_reset) begin
      host_to_secondary <= 1'b0;
      host_pass_on <= 1'b0;
      host_master_abort <= 1'b0;
    end else begin
      host_to_secondary <= host_valid & h_hit;
      host_pass_on <= host_valid & ~h_hit & ~last_in_chain;
      host_master_abort <= host_valid & ~h_hit & last_in_chain;
    end
  end

  // Secondary-side claim; a claimed cycle is always answered with medium timing.
  always_ff @(posedge clock) begin
    if (reset | power_good_reset) begin
      sec_claim <= 1'b0;
    end else begin
      sec_claim <= sec_valid & s_ok & ~s_hit;
    end
  end
  assign sec_devsel_timing = devsel_medium;
endmodule : bridge_window_decode_status
`default_nettype wire

//--- verilog/bridge_window_pkg.sv
// Constants for the bridge address-window decoder and secondary status block.
package bridge_window_pkg;
  // Byte offsets of the words; 0x14 holds the upper base address half.
  localparam logic [7:0] hotplug_base_lo_offset = 8'h10;
  localparam logic [7:0] hotplug_base_hi_offset = 8'h14;
  localparam logic [7:0] bus_numbers_offset = 8'h18;
  localparam logic [7:0] status_io_low_offset = 8'h1c;
  localparam logic [7:0] nonprefetch_offset = 8'h20;
  localparam logic [7:0] prefetch_low_offset = 8'h24;
  localparam logic [7:0] prefetch_base_hi_offset = 8'h28;
  localparam logic [7:0] prefetch_limit_hi_offset = 8'h2c;
  localparam logic [7:0] io_upper_offset = 8'h30;
  localparam logic [7:0] control_offset = 8'h3c;
  localparam logic [7:0] upper_ext_offset = 8'hd8;
  localparam logic [7:0] hotplug_enable_offset = 8'h48;

  localparam logic [3:0] hotplug_base_low_bits = 4'h4;
  localparam logic [7:0] latency_pci_reset = 8'h00;
  localparam logic [7:0] latency_pcix_reset = 8'h40;
  localparam logic [31:0] status_io_reset = 32'h022001f1;
  localparam logic [31:0] nonprefetch_reset = 32'h0000fff0;
  localparam logic [31:0] prefetch_low_reset = 32'h0001fff1;
  localparam logic [31:0] io_upper_reset = 32'h0000ffff;
  localparam logic [1:0] devsel_medium = 2'b01;
  localparam logic [6:0] status_fixed_bits = 7'h20;
  localparam int flag_parity = 31;
  localparam int flag_system_error = 30;
  localparam int flag_master_abort = 29;
  localparam int flag_target_abort = 28;
  localparam int flag_target_signalled = 27;
  localparam int flag_master_parity = 24;
endpackage : bridge_window_pkg

//--- testbench/bridge_window_decode_props.sv
// Concurrent checks on the ports of the bridge window decoder.
`timescale 1ns/1ps
`default_nettype none
module bridge_window_decode_props
  import bridge_window_pkg::*;
(
  // Clock and resets.
  input wire logic clock,
  input wire logic reset,
  input wire logic power_good_reset,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Decode.
  input wire logic last_in_chain,
  input wire logic host_valid,
  input wire logic host_to_secondary,
  input wire logic host_pass_on,
  input wire logic host_master_abort,
  input wire logic sec_valid,
  input wire logic sec_is_io,
  input wire logic [63:0] sec_addr,
  input wire logic sec_claim,
  input wire logic [1:0] sec_devsel_timing,
  // Hot-plug.
  input wire logic hotplug_enable,
  input wire logic [39:0] hotplug_base_address
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || power_good_reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  property p_hp_off;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && !hotplug_enable
      && wb_adr_i == hotplug_base_lo_offset |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  property p_host;
    host_valid |=> $onehot({host_to_secondary, host_pass_on, host_master_abort});
  endproperty
  property p_host_idle;
    !host_valid |=> !(host_to_secondary || host_pass_on || host_master_abort);
  endproperty
  property p_chain;
    host_valid |=> !(host_master_abort && !$past(last_in_chain))
      && !(host_pass_on && $past(last_in_chain));
  endproperty
  property p_sec_idle;
    !sec_valid |=> !sec_claim;
  endproperty
  property p_io_hi;
    sec_valid && sec_is_io && (|sec_addr[63:25]) |=> !sec_claim;
  endproperty
  property p_mem_hi;
    sec_valid && !sec_is_io && (|sec_addr[63:40]) |=> !sec_claim;
  endproperty
  property p_devsel;
    sec_devsel_timing == devsel_medium;
  endproperty
  property p_hp_low;
    hotplug_base_address[11:0] == 12'h000;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse after request");
  a_hp_off: assert property (p_hp_off) else $error("hot-plug base visible");
  a_host: assert property (p_host) else $error("host route not one-hot");
  a_host_idle: assert property (p_host_idle) else $error("host route without request");
  a_chain: assert property (p_chain) else $error("chain position ignored");
  a_sec_idle: assert property (p_sec_idle) else $error("claim without request");
  a_io_hi: assert property (p_io_hi) else $error("high io address claimed");
  a_mem_hi: assert property (p_mem_hi) else $error("high memory address claimed");
  a_devsel: assert property (p_devsel) else $error("select timing not medium");
  a_hp_low: assert property (p_hp_low) else $error("hot-plug base low bits set");
endmodule : bridge_window_decode_props
bind bridge_window_decode_status bridge_window_decode_props i_bridge_window_decode_props (
  .clock, .reset, .power_good_reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .last_in_chain, .host_valid, .host_to_secondary, .host_pass_on,
  .host_master_abort, .sec_valid, .sec_is_io, .sec_addr, .sec_claim, .sec_devsel_timing,
  .hotplug_enable, .hotplug_base_address);
`default_nettype wire

//--- testbench/bridge_far_agents.sv
// Behavioural secondary-bus agents that drive the error pins and event pulses.
`timescale 1ns/1ps
`default_nettype none
module bridge_far_agents (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Requests from the bench.
  input wire logic [1:0] err_req,
  input wire logic [6:0] ev_req,
  // Pins toward the bridge.
  output logic sys_err_n,
  output logic hp_err,
  output logic [6:0] ev
);
  // The system-error pin idles high through its pull-up, so reset releases it.
  always_ff @(posedge clock) begin
    sys_err_n <= reset ? 1'b1 : !err_req[0];
    hp_err <= reset ? 1'b0 : err_req[1];
  end
  // Events are single-cycle pulses because the bench requests them one cycle.
  always_ff @(posedge clock) begin
    ev <= reset ? 7'h00 : ev_req;
  end
endmodule : bridge_far_agents
`default_nettype wire

//--- testbench/bridge_window_decode_status_tb.sv
// Self-checking bench for the bridge window decoder and secondary status.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module bridge_window_decode_status_tb;
  logic clock = 0, reset = 1, pg = 1, pcix = 1, last = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, r;
  logic ack, h2s, pass, abt, claim, hpen, sys_n, hperr;
  logic hv = 0, hio = 0, sv = 0, sio = 0, dv_q = 0;
  logic [39:0] haddr = 40'h0, hpbase;
  logic [63:0] saddr = 64'h0, e;
  logic [1:0] devsel, err_req = 2'b00;
  logic [6:0] evr = 7'h00, ev;
  logic [63:0] rq[$];
  logic [3:0] dq[$];
  int err_count = 0, num_checks = 0, ticks = 0;
  int fb[7] = '{31, 31, 29, 28, 27, 24, 24};
  localparam logic [31:0] st = 32'h02203021;
  localparam logic [31:0] sm = 32'hfffff0ff;
  always #10 clock = ~clock;
  bridge_window_decode_status i_bridge_window_decode_status (
    .clock, .reset, .power_good_reset(pg), .pcix_mode(pcix), .last_in_chain(last),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_valid(hv), .host_is_io(hio),
    .host_addr(haddr), .host_to_secondary(h2s), .host_pass_on(pass),
    .host_master_abort(abt), .sec_valid(sv), .sec_is_io(sio), .sec_addr(saddr),
    .sec_claim(claim), .sec_devsel_timing(devsel), .ev_addr_parity(ev[0]),
    .ev_upstream_data_parity(ev[1]), .ev_master_abort(ev[2]), .ev_target_abort(ev[3]),
    .ev_target_abort_signalled(ev[4]), .ev_read_data_parity(ev[5]),
    .ev_write_parity_error(ev[6]), .secondary_system_error_in_n(sys_n),
    .hotplug_system_error_in(hperr), .hotplug_enable(hpen), .hotplug_base_address(hpbase));
  bridge_far_agents i_bridge_far_agents (.clock, .reset(reset || pg), .err_req,
    .ev_req(evr), .sys_err_n(sys_n), .hp_err(hperr), .ev);
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // A read notes its expected word and mask; the monitor compares at ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hffffffff);
    @(posedge clock);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    if (!w) rq.push_back({d, m});
    do @(posedge clock); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic dec(input logic s, input logic io, input logic [63:0] a,
                     input logic [3:0] x);
    @(posedge clock);
    {hv, sv, hio, sio, haddr, saddr} <= {!s, s, io, io, a[39:0], a};
    dq.push_back(x);
    @(posedge clock);
    {hv, sv} <= 2'b00;
  endtask : dec
  task automatic pulse(input int i);
    @(posedge clock);
    evr <= 7'h01 << i;
    @(posedge clock);
    evr <= 7'h00;
  endtask : pulse
  task automatic rs(input logic p);
    @(posedge clock);
    {reset, pg} <= {1'b1, p};
    repeat (2) @(posedge clock);
    {reset, pg} <= 2'b00;
  endtask : rs
  always @(posedge clock) begin
    if (ack === 1'b1 && !we) begin
      e = rq.pop_front();
      `CHK(rdat & e[31:0], e[63:32] & e[31:0])
    end
    if (dv_q) `CHK({h2s, pass, abt, claim}, dq.pop_front())
    dv_q <= hv | sv;
    ticks++;
    if (ticks == 5000) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(26753));
    repeat (12) @(posedge clock);
    {reset, pg} <= 2'b00;
    r = $urandom();
    wb(0, 8'h18, 32'h40000000);
    wb(0, 8'h1c, 32'h022001f1);
    wb(0, 8'h20, 32'h0000fff0);
    wb(0, 8'h40, 32'h0);
    wb(1, 8'h10, r);
    wb(0, 8'h10, 32'h0);
    wb(1, 8'h18, r);
    wb(0, 8'h18, r & 32'hf8ffffff);
    wb(1, 8'h48, 32'h1);
    wb(0, 8'h10, 32'h4);
    wb(1, 8'h10, r);
    wb(0, 8'h10, {r[31:12], 12'h004});
    wb(1, 8'h14, r & 32'hff);
    wb(0, 8'h14, r & 32'hff);
    wb(1, 8'h30, 32'h00010001);
    wb(1, 8'h1c, 32'h00003020);
    wb(1, 8'h20, 32'h12301200);
    wb(1, 8'hd8, 32'h00000101);
    dec(0, 1, 64'h12000, 4'h8);
    dec(0, 1, 64'h13fff, 4'h8);
    dec(0, 1, 64'h11fff, 4'h4);
    dec(0, 1, 64'hff_fe01_3000, 4'h8);
    dec(1, 1, 64'h12000, 4'h0);
    dec(1, 1, 64'h14000, 4'h1);
    dec(1, 1, 64'h8000_0000, 4'h0);
    dec(0, 0, 64'h01_1200_0000, 4'h8);
    dec(0, 0, 64'h01_123f_ffff, 4'h8);
    dec(1, 0, 64'h01_1240_0000, 4'h1);
    dec(1, 0, 64'h100_0000_0000, 4'h0);
    last <= 1;
    dec(0, 0, 64'h01_1240_0000, 4'h2);
    last <= 0;
    wb(1, 8'h24, 32'h20002000);
    wb(1, 8'h28, 32'h5);
    wb(1, 8'h2c, 32'h5);
    dec(0, 0, 64'h05_200f_ffff, 4'h8);
    dec(1, 0, 64'h05_2010_0000, 4'h1);
    wb(1, 8'hd8, 32'h00000102);
    wb(1, 8'h30, 32'h00000001);
    dec(0, 0, 64'h01_1200_0000, 4'h4);
    dec(1, 1, 64'h12000, 4'h1);
    pulse(5);
    wb(0, 8'h1c, st, sm);
    wb(1, 8'h3c, 32'h00010000);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      wb(0, 8'h1c, st | (32'h1 << fb[i]), sm);
      wb(1, 8'h1c, 32'h00003020 | (32'h1 << fb[i]));
      wb(0, 8'h1c, st, sm);
    end
    for (int i = 1; i < 4; i++) begin
      err_req <= i[1:0] & 2'b11;
      repeat (6) @(posedge clock);
      wb(1, 8'h1c, 32'h40003020);
      wb(0, 8'h1c, st | 32'h40000000, sm);
    end
    err_req <= 2'b00;
    repeat (6) @(posedge clock);
    wb(1, 8'h1c, 32'h40003020);
    wb(0, 8'h1c, st, sm);
    pulse(2);
    pcix <= 0;
    rs(0);
    wb(0, 8'h1c, 32'h222001f1);
    wb(0, 8'h18, 32'h0);
    rs(1);
    wb(0, 8'h1c, 32'h022001f1);
    repeat (3) @(posedge clock);
    complete_run;
  end
endmodule : bridge_window_decode_status_tb
`default_nettype wire
